// ### logic/rdwb_engine.v
`timescale 1ns/100ps
`default_nettype none
`include "rdwb_map.vh"

// Function
// - word0 bit15 set means device owns
// - device clears ownership after storing valid frame
// - released descriptor is never written again
// - secondary owner bit ignored, preserved
// - first buffer of frame gets first flag
// - last buffer gets last flag
// - flag unnumbered info frames
// - flag reject frame information field
// - transparent keep-bad: bit10 flags bad check
// - transparent filtering: bit9 marks local match
// - bit8 copies poll/final for ui/xid/test
// - word0 low byte left unchanged
// - word1 pointer read only, word aligned
// - word3 gets negated frame length when last
// - non-last buffer count equals buffer length
// - appended check bytes counted in length
// - append-check stores check bytes after data
// - keep-bad stores bad-check frames in transparent
// - ring entry spans four 16-bit words
module rdwb_engine (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // received byte stream
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_chk,
  input wire rx_end,
  output reg rx_ready,
  // per-frame attributes, valid with each byte
  input wire rx_ui,
  input wire rx_reject_info,
  input wire rx_bad_check,
  input wire rx_local_match,
  input wire rx_pf_valid,
  input wire rx_pf,
  // shared memory master, 16-bit words, byte addresses
  output reg mem_req,
  output reg mem_we,
  output reg [23:0] mem_addr,
  output reg [15:0] mem_wdata,
  output reg [1:0] mem_be,
  input wire mem_ack,
  input wire [15:0] mem_rdata,
  // frame stored and released
  output reg frame_done
);

  // ****************************************
  // states
  // ****************************************
  localparam S_IDLE = 4'h0;
  localparam S_RD0 = 4'h1;
  localparam S_RD1 = 4'h2;
  localparam S_RD2 = 4'h3;
  localparam S_FILL = 4'h4;
  localparam S_WDATA = 4'h5;
  localparam S_END = 4'h6;
  localparam S_WLEN = 4'h7;
  localparam S_WST = 4'h8;

  reg [3:0] state_reg;
  reg [4:0] ctrl_reg;
  reg [23:0] ring_base_reg;
  reg [2:0] ring_len_reg;
  reg [6:0] idx_reg;
  reg [6:0] first_idx_reg;
  reg stall_reg;
  reg [15:0] done_cnt_reg;
  reg [15:0] drop_cnt_reg;
  reg [15:0] w0_reg;
  reg [23:0] ptr_reg;
  reg [15:0] w2_reg;
  reg [15:0] buf_cnt_reg;
  reg [15:0] msg_cnt_reg;
  reg first_reg;
  reg last_reg;
  reg end_reg;
  reg [5:0] attr_reg;
  reg [31:0] rd_next;

  wire enable = ctrl_reg[`RDWB_CTRL_ENABLE];
  wire transparent = ctrl_reg[`RDWB_CTRL_TRANSPARENT];
  wire keep_bad = ctrl_reg[`RDWB_CTRL_KEEP_BAD];
  wire append = ctrl_reg[`RDWB_CTRL_APPEND_CHECK];
  wire [15:0] buf_len = 16'h0000 - w2_reg;
  wire accept = (state_reg == S_FILL) && rx_valid && rx_ready;
  // check bytes are dropped unless appending is on
  wire keep_byte = !rx_chk || append;
  wire [15:0] buf_cnt_inc = buf_cnt_reg + 16'h0001;
  wire [15:0] pk_word;
  wire [1:0] pk_be;
  wire [1:0] pk_fill;
  wire [15:0] st_word;
  wire pk_clear = (state_reg == S_WDATA) && mem_req && mem_ack;

  // ****************************************
  // helpers
  // ****************************************
  // each entry is four 16-bit words, eight bytes
  function [23:0] desc_addr;
    input [23:0] base;
    input [6:0] idx;
    input [1:0] word;
    begin
      desc_addr = base + {14'h0000, idx, 3'h0} + {21'h000000, word, 1'b0};
    end
  endfunction

  function [6:0] next_idx;
    input [6:0] idx;
    input [2:0] len_log2;
    begin
      next_idx = (idx + 7'h01) & ((7'h01 << len_log2) - 7'h01);
    end
  endfunction

  rdwb_pack u_pack (
    .pclk(pclk),
    .presetn(presetn),
    .load(accept && keep_byte),
    .in_byte(rx_data),
    .clear(pk_clear),
    .word(pk_word),
    .be(pk_be),
    .fill(pk_fill)
  );

  rdwb_status u_status (
    .word0_in(w0_reg),
    .first(first_reg),
    .last(last_reg),
    .is_ui(attr_reg[0]),
    .is_reject_info(attr_reg[1]),
    .bad_check(attr_reg[2]),
    .local_match(attr_reg[3]),
    .pf_valid(attr_reg[4]),
    .pf(attr_reg[5]),
    .transparent(transparent),
    .keep_bad(keep_bad),
    .addr_filter(ctrl_reg[`RDWB_CTRL_ADDR_FILTER]),
    .word0_out(st_word)
  );

  // ****************************************
  // apb slave: one wait state, pready from a flop
  // ****************************************
  wire apb_take = psel && penable && pready;
  wire apb_wr = apb_take && pwrite;
  reg rd_hit;

  always @* begin
    rd_next = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      `RDWB_OFF_CTRL: rd_next = {27'h0000000, ctrl_reg};
      `RDWB_OFF_RING_BASE: rd_next = {8'h00, ring_base_reg};
      `RDWB_OFF_RING_LEN: rd_next = {29'h00000000, ring_len_reg};
      `RDWB_OFF_STATUS: rd_next = {22'h000000, stall_reg, state_reg != S_IDLE, 1'b0, idx_reg};
      `RDWB_OFF_COUNTS: rd_next = {drop_cnt_reg, done_cnt_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      ctrl_reg <= `RDWB_CTRL_RESET;
      ring_base_reg <= `RDWB_RING_BASE_RESET;
      ring_len_reg <= `RDWB_RING_LEN_RESET;
    end else begin
      pready <= psel && penable && !pready;
      // the error flag stands only with pready, never into the next transfer
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h00000000 : rd_next;
        // status and counts are read only
        pslverr <= !rd_hit || (pwrite && (paddr == `RDWB_OFF_STATUS ||
                                          paddr == `RDWB_OFF_COUNTS));
      end
      if (apb_wr && paddr == `RDWB_OFF_CTRL) begin
        ctrl_reg <= pwdata[4:0];
      end
      // ring layout only changes while enable is clear; a frame still in progress after enable drops can see it move
      if (apb_wr && paddr == `RDWB_OFF_RING_BASE && !enable) begin
        ring_base_reg <= {pwdata[23:1], 1'b0};
      end
      if (apb_wr && paddr == `RDWB_OFF_RING_LEN && !enable) begin
        ring_len_reg <= pwdata[2:0];
      end
    end
  end

  // ****************************************
  // descriptor engine
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      idx_reg <= 7'h00;
      first_idx_reg <= 7'h00;
      stall_reg <= 1'b0;
      done_cnt_reg <= 16'h0000;
      drop_cnt_reg <= 16'h0000;
      w0_reg <= 16'h0000;
      ptr_reg <= 24'h000000;
      w2_reg <= 16'h0000;
      buf_cnt_reg <= 16'h0000;
      msg_cnt_reg <= 16'h0000;
      first_reg <= 1'b1;
      last_reg <= 1'b0;
      end_reg <= 1'b0;
      attr_reg <= 6'h00;
      rx_ready <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 24'h000000;
      mem_wdata <= 16'h0000;
      mem_be <= 2'h0;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          rx_ready <= 1'b0;
          if (!enable) begin
            idx_reg <= 7'h00;
            first_idx_reg <= 7'h00;
            first_reg <= 1'b1;
            msg_cnt_reg <= 16'h0000;
          end else begin
            state_reg <= S_RD0;
          end
        end
        S_RD0: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_be <= 2'h3;
            mem_addr <= desc_addr(ring_base_reg, idx_reg, `RDWB_W0);
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            w0_reg <= mem_rdata;
            // host-owned entry: poll again, touch nothing
            stall_reg <= !mem_rdata[`RDWB_B_OWN];
            state_reg <= mem_rdata[`RDWB_B_OWN] ? S_RD1 : S_IDLE;
          end
        end
        S_RD1: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_addr <= desc_addr(ring_base_reg, idx_reg, `RDWB_W1);
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            // bit 0 forced low, buffers start on a word boundary
            ptr_reg <= {w0_reg[`RDWB_PTR_HI_MSB:0], mem_rdata[15:1], 1'b0};
            state_reg <= S_RD2;
          end
        end
        S_RD2: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_addr <= desc_addr(ring_base_reg, idx_reg, `RDWB_W2);
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            w2_reg <= mem_rdata;
            rx_ready <= 1'b1;
            state_reg <= S_FILL;
          end
        end
        S_FILL: begin
          if (accept) begin
            attr_reg <= {rx_pf, rx_pf_valid, rx_local_match, rx_bad_check,
                         rx_reject_info, rx_ui};
            end_reg <= rx_end;
            if (keep_byte) begin
              buf_cnt_reg <= buf_cnt_inc;
              msg_cnt_reg <= msg_cnt_reg + 16'h0001;
            end
            if ((keep_byte && (pk_fill == 2'h1 || buf_cnt_inc == buf_len || rx_end)) ||
                (rx_end && pk_fill == 2'h1)) begin
              rx_ready <= 1'b0;
              state_reg <= S_WDATA;
            end else if (rx_end) begin
              rx_ready <= 1'b0;
              state_reg <= S_END;
            end
          end
        end
        S_WDATA: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_be <= pk_be;
            mem_wdata <= pk_word;
            mem_addr <= ptr_reg + {8'h00, buf_cnt_reg[15:1], 1'b0} -
                        {22'h000000, pk_be[1], pk_be[1] ^ (buf_cnt_reg[0] ^ 1'b1)} +
                        {22'h000000, 1'b0, 1'b0};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_be <= 2'h3;
            if (end_reg) begin
              state_reg <= S_END;
            end else if (buf_cnt_reg == buf_len) begin
              last_reg <= 1'b0;
              state_reg <= S_WLEN;
            end else begin
              rx_ready <= 1'b1;
              state_reg <= S_FILL;
            end
          end
        end
        S_END: begin
          end_reg <= 1'b0;
          // bad frames are dropped unless kept in transparent mode; a drop rewinds
          // to the first entry, but entries already chained out stay with the host
          if (attr_reg[2] && !(transparent && keep_bad)) begin
            drop_cnt_reg <= drop_cnt_reg + 16'h0001;
            idx_reg <= first_idx_reg;
            first_reg <= 1'b1;
            msg_cnt_reg <= 16'h0000;
            buf_cnt_reg <= 16'h0000;
            state_reg <= S_IDLE;
          end else begin
            last_reg <= 1'b1;
            state_reg <= S_WLEN;
          end
        end
        S_WLEN: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= desc_addr(ring_base_reg, idx_reg, `RDWB_W3);
            // a filled middle buffer reports the host's own length
            mem_wdata <= last_reg ? (16'h0000 - msg_cnt_reg) : w2_reg;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            state_reg <= S_WST;
          end
        end
        S_WST: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= desc_addr(ring_base_reg, idx_reg, `RDWB_W0);
            mem_wdata <= st_word;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            idx_reg <= next_idx(idx_reg, ring_len_reg);
            buf_cnt_reg <= 16'h0000;
            if (last_reg) begin
              first_reg <= 1'b1;
              first_idx_reg <= next_idx(idx_reg, ring_len_reg);
              msg_cnt_reg <= 16'h0000;
              done_cnt_reg <= done_cnt_reg + 16'h0001;
              frame_done <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              first_reg <= 1'b0;
              state_reg <= S_RD0;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule // rdwb_engine

`default_nettype wire

// ### logic/rdwb_map.vh
`ifndef RDWB_MAP_VH
`define RDWB_MAP_VH

// ****************************************
// apb register byte offsets
// ****************************************
`define RDWB_OFF_CTRL 8'h00
`define RDWB_OFF_RING_BASE 8'h04
`define RDWB_OFF_RING_LEN 8'h08
`define RDWB_OFF_STATUS 8'h0c
`define RDWB_OFF_COUNTS 8'h10

// ****************************************
// control register fields and reset values
// ****************************************
`define RDWB_CTRL_ENABLE 0
`define RDWB_CTRL_TRANSPARENT 1
`define RDWB_CTRL_KEEP_BAD 2
`define RDWB_CTRL_APPEND_CHECK 3
`define RDWB_CTRL_ADDR_FILTER 4
`define RDWB_CTRL_RESET 5'h00
`define RDWB_RING_BASE_RESET 24'h000000
`define RDWB_RING_LEN_RESET 3'h0

// ****************************************
// status register fields
// ****************************************
`define RDWB_STAT_BUSY 8
`define RDWB_STAT_STALL 9

// ****************************************
// descriptor layout: four 16-bit words per ring entry
// ****************************************
`define RDWB_DESC_BYTES 4'h8
`define RDWB_W0 2'h0
`define RDWB_W1 2'h1
`define RDWB_W2 2'h2
`define RDWB_W3 2'h3
`define RDWB_B_OWN 15
`define RDWB_B_SECOND 14
`define RDWB_B_FIRST 13
`define RDWB_B_LAST 12
`define RDWB_B_UI 11
`define RDWB_B_REJECT 10
`define RDWB_B_ADDR 9
`define RDWB_B_PF 8
`define RDWB_PTR_HI_MSB 7

`endif

// ### logic/rdwb_pack.v
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// byte pair assembler: low byte first at the even address
// ****************************************
module rdwb_pack (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // byte side
  input wire load,
  input wire [7:0] in_byte,
  input wire clear,
  // word side
  output wire [15:0] word,
  output wire [1:0] be,
  output wire [1:0] fill
);

  reg [7:0] lo_reg;
  reg [7:0] hi_reg;
  reg [1:0] cnt_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_reg <= 8'h00;
      hi_reg <= 8'h00;
      cnt_reg <= 2'h0;
    end else if (clear) begin
      cnt_reg <= 2'h0;
    end else if (load) begin
      if (cnt_reg == 2'h0) begin
        lo_reg <= in_byte;
      end else begin
        hi_reg <= in_byte;
      end
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  assign word = {hi_reg, lo_reg};
  assign be = {cnt_reg == 2'h2, cnt_reg != 2'h0};
  assign fill = cnt_reg;

endmodule // rdwb_pack

`default_nettype wire

// ### logic/rdwb_status.v
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// word 0 writeback image
// ****************************************
module rdwb_status (
  // descriptor word 0 as read
  input wire [15:0] word0_in,
  // frame attributes
  input wire first,
  input wire last,
  input wire is_ui,
  input wire is_reject_info,
  input wire bad_check,
  input wire local_match,
  input wire pf_valid,
  input wire pf,
  // mode
  input wire transparent,
  input wire keep_bad,
  input wire addr_filter,
  // writeback image
  output wire [15:0] word0_out
);

  wire reject_bit;
  wire addr_bit;

  // in transparent keep-bad mode the reject bit reports a bad check instead
  assign reject_bit = (transparent && keep_bad) ? bad_check : is_reject_info;
  assign addr_bit = transparent && addr_filter && local_match;

  // ownership goes back to the host in the same write as the status
  assign word0_out = {1'b0,
                      word0_in[`RDWB_B_SECOND],
                      first,
                      last,
                      is_ui,
                      reject_bit,
                      addr_bit,
                      pf_valid & pf,
                      word0_in[`RDWB_PTR_HI_MSB:0]};

endmodule // rdwb_status

`default_nettype wire

// ### tb/rdwb_host_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// host side shared memory
// ****
module rdwb_host_mem (
  // clock and pace
  input wire logic pclk,
  input wire logic slow,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [1:0] mem_be,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  // illegal descriptor write seen
  output logic bad_wr
);
  logic [15:0] mem [0:511];
  logic [15:0] last = 16'h0000;
  logic [2:0] dly = 3'h0;
  wire [8:0] wi = mem_addr[9:1];
  wire [8:0] w0i = {wi[8:2], 2'h0};
  wire in_ring = mem_addr[9:4] == 6'h10;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
    bad_wr = 1'b0;
    // ring entries not yet armed read as host owned
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  always @(posedge pclk) begin
    mem_ack <= 1'b0;
    bad_wr <= 1'b0;
    // released bus shows the inverse, never the stale word
    if (mem_ack) mem_rdata <= ~last;
    if (mem_req && !mem_ack && dly != 3'h0) dly <= dly - 3'h1;
    else if (mem_req && !mem_ack) begin
      mem_ack <= 1'b1;
      dly <= slow ? 3'h4 : 3'h0;
      if (!mem_we) begin
        mem_rdata <= mem[wi];
        last <= mem[wi];
      end
      if (mem_we && mem_be[0]) mem[wi][7:0] <= mem_wdata[7:0];
      if (mem_we && mem_be[1]) mem[wi][15:8] <= mem_wdata[15:8];
      if (mem_we && in_ring && (!mem[w0i][15] || wi[1] != wi[0])) bad_wr <= 1'b1;
    end
  end
endmodule // rdwb_host_mem
`default_nettype wire

// ### tb/rdwb_props.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// engine port checker
// ****
module rdwb_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // rx stream
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic rx_end,
  // memory and completion
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic frame_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // last word 0 read; its host fields must come back untouched
  logic [23:0] w0_addr;
  logic [15:0] w0_seen;
  wire w0_wr = mem_req && mem_ack && mem_we && mem_addr == w0_addr;
  wire last_rel = w0_wr && mem_wdata[12];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w0_addr <= 24'hffffff;
      w0_seen <= 16'h0000;
    end else if (mem_req && mem_ack && !mem_we && mem_addr[2:1] == 2'h0) begin
      w0_addr <= mem_addr;
      w0_seen <= mem_rdata;
    end
  end
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_ready_one: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_qual: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_wdata) && $stable(mem_we)) else $error("memory request moved");
  a_req_drop: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request held after ack");
  a_w0_release: assert property (w0_wr |-> !mem_wdata[15])
    else $error("descriptor not released");
  a_w0_keep: assert property (w0_wr |-> mem_wdata[14] == w0_seen[14])
    else $error("secondary owner bit altered");
  a_addr_keep: assert property (w0_wr |-> mem_wdata[7:0] == w0_seen[7:0])
    else $error("pointer high byte altered");
  a_done_after: assert property (frame_done |-> $past(last_rel))
    else $error("frame done without last release");
  a_done_one: assert property (frame_done |=> !frame_done)
    else $error("frame done longer than one cycle");
  a_rx_stop: assert property (rx_valid && rx_ready && rx_end |=> !rx_ready)
    else $error("byte taken past frame end");
  c_done: cover property (frame_done);
  c_err: cover property (pslverr);
  c_chain: cover property (w0_wr && mem_wdata[13] && !mem_wdata[12]);
endmodule // rdwb_props
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("Error at %0t got %h expected %h", $time, g, e); end end
module tb_top;
  // ****
  // stimulus and wiring
  // ****
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, rx_data = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rx_ready, mem_req, mem_we, mem_ack, frame_done, bad_wr, er;
  logic rx_valid = 1'b0, rx_chk = 1'b0, rx_end = 1'b0, slow = 1'b0;
  logic rx_ui = 1'b0, rx_reject_info = 1'b0, rx_bad_check = 1'b0;
  logic rx_local_match = 1'b0, rx_pf_valid = 1'b0, rx_pf = 1'b0;
  logic [23:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [1:0] mem_be;
  int err_count = 0, checked = 0, cyc = 0;
  always #20 pclk = ~pclk;
  rdwb_engine dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_valid, .rx_data, .rx_chk, .rx_end, .rx_ready, .rx_ui,
    .rx_reject_info, .rx_bad_check, .rx_local_match, .rx_pf_valid, .rx_pf, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_be, .mem_ack, .mem_rdata, .frame_done);
  rdwb_host_mem m (.pclk, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be,
    .mem_ack, .mem_rdata, .bad_wr);
  // ****
  // bus, host and stream tasks
  // ****
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // host prepares the entry and hands it over last
  task arm(input int e, input logic [15:0] w0, input logic [15:0] lo, input logic [15:0] n);
    for (int k = 0; k < 4; k++) m.mem[lo[9:1] + k] = 16'heeee;
    m.mem[128 + 4 * e + 1] = lo;
    m.mem[128 + 4 * e + 2] = n;
    m.mem[128 + 4 * e + 3] = 16'h0000;
    m.mem[128 + 4 * e] = w0;
  endtask
  task frame(input int n, input int nc, input logic [7:0] b0, input logic [5:0] at,
    input bit drop = 1'b0);
    {rx_ui, rx_reject_info, rx_bad_check, rx_local_match, rx_pf_valid, rx_pf} <= at;
    for (int k = 0; k < n + nc; k++) begin
      rx_data <= b0 + k[7:0];
      rx_chk <= k >= n;
      rx_end <= k == n + nc - 1;
      rx_valid <= 1'b1;
      do @(posedge pclk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    // a dropped frame never releases, so only one edge passes
    do @(posedge pclk); while (!drop && frame_done !== 1'b1);
  endtask
  // ****
  // scenarios
  // ****
  task t_regs;
    apb(1'b0, 8'h00, 32'h0);
    `CHK({er, rd}, 33'h0)
    apb(1'b1, 8'h04, 32'h100);
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h100)
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b0, 8'h14, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    apb(1'b1, 8'h0c, 32'hffff);
    `CHK(er, 1'b1)
  endtask
  task t_single;
    arm(0, 16'hff5a, 16'h0200, 16'hfffc);
    apb(1'b1, 8'h00, 32'h1);
    frame(3, 0, 8'ha1, 6'b110111);
    `CHK(m.mem[128], 16'h7d5a)
    `CHK(m.mem[131], 16'hfffd)
    `CHK({m.mem[129], m.mem[130]}, 32'h0200fffc)
    `CHK({m.mem[256], m.mem[257]}, 32'ha2a1eea3)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(rd[6:0], 7'h01)
    apb(1'b0, 8'h10, 32'h0);
    `CHK(rd[15:0], 16'h0001)
  endtask
  task t_chain;
    slow <= 1'b1;
    arm(1, 16'h8000, 16'h0280, 16'hfffc);
    arm(0, 16'h8000, 16'h0300, 16'hfffc);
    frame(6, 0, 8'h01, 6'b000000);
    `CHK({m.mem[132], m.mem[135]}, 32'h2000fffc)
    `CHK({m.mem[128], m.mem[131]}, 32'h1000fffa)
    `CHK({m.mem[320], m.mem[321], m.mem[384]}, 48'h020104030605)
    slow <= 1'b0;
  endtask
  task t_modes;
    arm(1, 16'h8000, 16'h0280, 16'hfff8);
    apb(1'b1, 8'h00, 32'h1f);
    frame(2, 2, 8'h11, 6'b001100);
    `CHK({m.mem[132], m.mem[135]}, 32'h3600fffc)
    `CHK({m.mem[320], m.mem[321]}, 32'h12111413)
  endtask
  task t_drop;
    apb(1'b1, 8'h00, 32'h1);
    arm(0, 16'h8000, 16'h0300, 16'hfffc);
    frame(2, 0, 8'h31, 6'b001000, 1'b1);
    frame(1, 0, 8'h41, 6'b000000);
    `CHK({m.mem[128], m.mem[131], m.mem[384]}, 48'h3000ffff3241)
    apb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h00010004)
  endtask
  task final_report;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (bad_wr) `CHK(bad_wr, 1'b0)
    if (cyc == 20000) begin
      err_count++;
      final_report;
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_single;
    t_chain;
    t_modes;
    t_drop;
    final_report;
  end
endmodule // tb_top
bind rdwb_engine rdwb_props u_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .rx_valid, .rx_ready, .rx_end, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
  .mem_rdata, .frame_done);
`default_nettype wire
